// file: verilog/spimf_pkg.sv
// Constants and types shared by the mode-fault detection block
// ==========================================================================
// Behaviour
// - A set mode fault flag raises the receive/error interrupt when the error interrupt enable is set.
// - Receive full, mode fault and overrun all drive the one shared receive/error interrupt output.
// - Mode fault and overrun have no enables of their own, and with fault detection off the fault flag never sets.
// - A master with fault detection on flags a mode fault when slave select is seen low.
// - A master mode fault clears port enable, sets transmit empty and clears the transfer state counter.
// - After a master mode fault the shared pins go back to the port's own direction settings.
// - A slave flags a mode fault when slave select goes high while a transmission is in progress.
// - With clock phase 0 a slave transmission starts on slave select falling and ends when the clock idles after eight bits.
// - With clock phase 1 a slave transmission starts when the clock leaves idle with select low and ends when it idles after the last bit.
// - With clock phase 0 selecting and then deselecting a slave flags a fault even with no clock edge between.
// - Setting the mode fault flag leaves master select unchanged.
// - Master select has no effect while port enable is 0.
// - While the fault flag is set, reading master select tells whether the fault arose as master or slave.
package spimf_pkg;
	// ==========================================================================
	// Framing and timing
	localparam int BITS_PER_WORD = 8;
	localparam int CLOCK_PERIOD_NS = 8;
	localparam int SCLK_HALF_NS = 64;
	localparam int SCLK_HALF_CYCLES = (SCLK_HALF_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int EDGES_PER_WORD = 2 * BITS_PER_WORD;
	localparam int BUF_DEPTH = 2;
	// ==========================================================================
	// Reset values
	localparam logic PORT_ENABLE_RST = 1'b0;
	localparam logic MASTER_SELECT_RST = 1'b0;
	localparam logic ERROR_IRQ_ENABLE_RST = 1'b0;
	localparam logic RX_IRQ_ENABLE_RST = 1'b0;
	localparam logic MODE_FAULT_RST = 1'b0;
	localparam logic OVERRUN_RST = 1'b0;
	localparam logic TRANSMIT_EMPTY_RST = 1'b1;
	localparam logic SELECT_IDLE = 1'b1;
	// ==========================================================================
	// Master sequencer
	typedef enum {MST_IDLE, MST_RUN} spimf_mstate_t;
endpackage : spimf_pkg

// file: verilog/spimf_sync.sv
// Two-flop level synchroniser
`timescale 1ns/1ns
module spimf_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	// Level in and out
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	// First stage feeds only the second
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			meta_q <= RESET_VAL;
			sync_q <= RESET_VAL;
		end else begin
			meta_q <= i_async;
			sync_q <= meta_q;
		end
	end

	assign o_sync = sync_q;
endmodule : spimf_sync

// file: verilog/spimf_buf.sv
// Two-entry valid/ready buffer for received words
`timescale 1ns/1ns
module spimf_buf #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
) (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	// Filling side
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [WIDTH-1:0] i_in_data,
	// Draining side
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [WIDTH-1:0] o_out_data
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW-1:0] wr_q;
	logic [PW-1:0] rd_q;
	logic [PW:0] count_q;
	logic push;
	logic pop;

	assign o_in_ready = (count_q != (PW+1)'(DEPTH));
	assign o_out_valid = (count_q != '0);
	assign push = i_in_valid && o_in_ready;
	assign pop = o_out_valid && i_out_ready;
	assign o_out_data = mem_q[rd_q];

	function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
		next_ptr = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
	endfunction : next_ptr

	always_ff @(posedge i_clock) begin
		if (push) begin
			mem_q[wr_q] <= i_in_data;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			wr_q <= '0;
			rd_q <= '0;
			count_q <= '0;
		end else begin
			if (push) begin
				wr_q <= next_ptr(wr_q);
			end
			if (pop) begin
				rd_q <= next_ptr(rd_q);
			end
			if (push && !pop) begin
				count_q <= count_q + 1'b1;
			end else if (pop && !push) begin
				count_q <= count_q - 1'b1;
			end
		end
	end
endmodule : spimf_buf

// file: verilog/spimf_top.sv
// Serial peripheral port with mode-fault detection and transfer framing
`timescale 1ns/1ns
module spimf_top
	import spimf_pkg::*;
#(
	parameter int WORD_BITS = BITS_PER_WORD,
	parameter int HALF_CYCLES = SCLK_HALF_CYCLES
) (
	// System clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	// Control write
	input wire logic i_ctrl_wr,
	input wire logic i_wr_port_enable,
	input wire logic i_wr_master_select,
	input wire logic i_wr_error_irq_enable,
	input wire logic i_wr_rx_irq_enable,
	// Static configuration
	input wire logic i_fault_detect_enable,
	input wire logic i_clock_phase,
	input wire logic i_clock_polarity,
	// Flag clears
	input wire logic i_mode_fault_clear,
	input wire logic i_overrun_clear,
	// Status
	output logic o_port_enable,
	output logic o_master_select,
	output logic o_error_irq_enable,
	output logic o_rx_irq_enable,
	output logic o_mode_fault_flag,
	output logic o_overrun_flag,
	output logic o_transmit_empty_flag,
	output logic o_receive_full_flag,
	output logic o_pins_by_port,
	output logic o_rx_error_irq,
	// Transmit word
	input wire logic i_tx_valid,
	output logic o_tx_ready,
	input wire logic [WORD_BITS-1:0] i_tx_data,
	// Received words
	output logic o_rx_valid,
	input wire logic i_rx_ready,
	output logic [WORD_BITS-1:0] o_rx_data,
	// Link pins
	input wire logic i_serial_clock,
	input wire logic i_select_n,
	input wire logic i_mosi,
	input wire logic i_miso,
	output logic o_serial_clock,
	output logic o_serial_clock_oe,
	output logic o_mosi,
	output logic o_mosi_oe
);
	localparam int CW = $clog2(WORD_BITS + 1);
	localparam int EW = $clog2(EDGES_PER_WORD);
	localparam int HW = $clog2(HALF_CYCLES + 1);

	// ==========================================================================
	// Control bits
	logic port_enable_q;
	logic master_select_q;
	logic error_irq_enable_q;
	logic rx_irq_enable_q;
	logic mode_fault_q;
	logic overrun_q;
	logic transmit_empty_q;
	logic master_fault;
	logic slave_fault;
	logic is_master;
	logic is_slave;

	// Role only counts while the port is on
	assign is_master = port_enable_q && master_select_q;
	assign is_slave = port_enable_q && !master_select_q;

	// Fault wins over an enable written in the same cycle
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			port_enable_q <= PORT_ENABLE_RST;
		end else if (master_fault) begin
			port_enable_q <= 1'b0;
		end else if (i_ctrl_wr) begin
			port_enable_q <= i_wr_port_enable;
		end
	end

	// Only software moves the role bit
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			master_select_q <= MASTER_SELECT_RST;
			error_irq_enable_q <= ERROR_IRQ_ENABLE_RST;
			rx_irq_enable_q <= RX_IRQ_ENABLE_RST;
		end else if (i_ctrl_wr) begin
			master_select_q <= i_wr_master_select;
			error_irq_enable_q <= i_wr_error_irq_enable;
			rx_irq_enable_q <= i_wr_rx_irq_enable;
		end
	end

	// ==========================================================================
	// Pin sampling
	logic select_s;
	logic sclk_s;
	logic miso_s;
	logic select_d1_q;
	logic sclk_d1_q;
	logic sclk_idle;

	spimf_sync #(
		.WIDTH(3),
		.RESET_VAL({SELECT_IDLE, 1'b0, 1'b0})
	) u_pin_sync (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_async({i_select_n, i_serial_clock, i_miso}),
		.o_sync({select_s, sclk_s, miso_s})
	);

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			select_d1_q <= SELECT_IDLE;
			sclk_d1_q <= 1'b0;
		end else begin
			select_d1_q <= select_s;
			sclk_d1_q <= sclk_s;
		end
	end

	assign sclk_idle = (sclk_s == i_clock_polarity);

	// ==========================================================================
	// Link clock domain: slave shifter
	logic link_clk;
	logic [CW-1:0] lk_bits_q;
	logic [WORD_BITS-1:0] lk_shift_q;
	logic [WORD_BITS-1:0] lk_hold_q;
	logic lk_toggle_q;
	logic word_toggle_s;
	logic word_toggle_d1_q;
	logic slave_word;

	// Sample edge is the rising edge for modes 0 and 3
	assign link_clk = i_serial_clock ^ i_clock_polarity ^ i_clock_phase;

	// Deselect clears the bit count, so a broken word never completes
	always_ff @(posedge link_clk or posedge i_select_n) begin
		if (i_select_n) begin
			lk_bits_q <= '0;
		end else if (lk_bits_q == CW'(WORD_BITS - 1)) begin
			lk_bits_q <= '0;
		end else begin
			lk_bits_q <= lk_bits_q + 1'b1;
		end
	end

	always_ff @(posedge link_clk) begin
		lk_shift_q <= {lk_shift_q[WORD_BITS-2:0], i_mosi};
	end

	// Hold stays put for a whole word, long enough for the toggle to cross
	always_ff @(posedge link_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			lk_hold_q <= '0;
			lk_toggle_q <= 1'b0;
		end else if (!i_select_n && lk_bits_q == CW'(WORD_BITS - 1)) begin
			lk_hold_q <= {lk_shift_q[WORD_BITS-2:0], i_mosi};
			lk_toggle_q <= ~lk_toggle_q;
		end
	end

	spimf_sync #(
		.WIDTH(1),
		.RESET_VAL(1'b0)
	) u_word_sync (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_async(lk_toggle_q),
		.o_sync(word_toggle_s)
	);

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			word_toggle_d1_q <= 1'b0;
		end else begin
			word_toggle_d1_q <= word_toggle_s;
		end
	end

	assign slave_word = (word_toggle_s != word_toggle_d1_q);

	// ==========================================================================
	// Slave transmission framing
	logic in_progress_q;
	logic word_done_q;
	logic select_fall;
	logic select_rise;
	logic sclk_leaves_idle;

	assign select_fall = select_d1_q && !select_s;
	assign select_rise = !select_d1_q && select_s;
	assign sclk_leaves_idle = (sclk_d1_q == i_clock_polarity) && !sclk_idle;

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			in_progress_q <= 1'b0;
			word_done_q <= 1'b0;
		end else if (!is_slave || select_s) begin
			in_progress_q <= 1'b0;
			word_done_q <= 1'b0;
		end else if (!i_clock_phase && select_fall) begin
			in_progress_q <= 1'b1;
			word_done_q <= 1'b0;
		end else if (i_clock_phase && !in_progress_q && sclk_leaves_idle) begin
			in_progress_q <= 1'b1;
			word_done_q <= 1'b0;
		end else if (slave_word) begin
			word_done_q <= 1'b1;
		end else if (word_done_q && sclk_idle) begin
			in_progress_q <= 1'b0;
			word_done_q <= 1'b0;
		end
	end

	// Select rising with a word open, clocked or not
	assign slave_fault = is_slave && i_fault_detect_enable && select_rise && in_progress_q;

	// ==========================================================================
	// Master sequencer
	spimf_mstate_t mst_q;
	logic [HW-1:0] half_q;
	logic [EW-1:0] edge_q;
	logic [WORD_BITS-1:0] tx_hold_q;
	logic [WORD_BITS-1:0] mst_shift_q;
	logic [WORD_BITS-1:0] mst_rx_q;
	logic mst_sclk_q;
	logic mst_push_q;
	logic buf_in_ready;
	logic half_done;
	logic mst_start;

	assign master_fault = is_master && i_fault_detect_enable && !select_s;
	assign half_done = (half_q == HW'(HALF_CYCLES - 1));
	// Start only when the buffer can take the answer
	assign mst_start = is_master && !master_fault && !transmit_empty_q && buf_in_ready;
	assign o_tx_ready = transmit_empty_q && is_master;

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			mst_q <= MST_IDLE;
			half_q <= '0;
			edge_q <= '0;
			mst_sclk_q <= 1'b0;
			mst_push_q <= 1'b0;
			mst_shift_q <= '0;
			mst_rx_q <= '0;
		end else begin
			mst_push_q <= 1'b0;
			unique case (mst_q)
				MST_IDLE: begin
					mst_sclk_q <= i_clock_polarity;
					half_q <= '0;
					edge_q <= '0;
					if (mst_start) begin
						mst_shift_q <= tx_hold_q;
						mst_q <= MST_RUN;
					end
				end
				MST_RUN: begin
					if (master_fault || !is_master) begin
						mst_q <= MST_IDLE;
						edge_q <= '0;
						half_q <= '0;
					end else if (half_done) begin
						half_q <= '0;
						mst_sclk_q <= ~mst_sclk_q;
						if (edge_q[0] == i_clock_phase) begin
							mst_rx_q <= {mst_rx_q[WORD_BITS-2:0], miso_s};
						end else if (edge_q != '0) begin
							mst_shift_q <= {mst_shift_q[WORD_BITS-2:0], 1'b0};
						end
						if (edge_q == EW'(EDGES_PER_WORD - 1)) begin
							mst_q <= MST_IDLE;
							mst_push_q <= 1'b1;
						end else begin
							edge_q <= edge_q + 1'b1;
						end
					end else begin
						half_q <= half_q + 1'b1;
					end
				end
			endcase
		end
	end

	// Fault wins over a word offered in the same cycle
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			transmit_empty_q <= TRANSMIT_EMPTY_RST;
			tx_hold_q <= '0;
		end else if (master_fault) begin
			transmit_empty_q <= 1'b1;
		end else if (i_tx_valid && o_tx_ready) begin
			tx_hold_q <= i_tx_data;
			transmit_empty_q <= 1'b0;
		end else if (mst_q == MST_IDLE && mst_start) begin
			transmit_empty_q <= 1'b1;
		end
	end

	// Pins go back to the port once the interface is off
	assign o_pins_by_port = !is_master;
	assign o_serial_clock = mst_sclk_q;
	assign o_serial_clock_oe = is_master;
	assign o_mosi = mst_shift_q[WORD_BITS-1];
	assign o_mosi_oe = is_master;

	// ==========================================================================
	// Receive buffer and flags
	logic buf_push;
	logic [WORD_BITS-1:0] buf_data;

	assign buf_push = mst_push_q || (slave_word && is_slave);
	assign buf_data = mst_push_q ? mst_rx_q : lk_hold_q;

	spimf_buf #(
		.WIDTH(WORD_BITS),
		.DEPTH(BUF_DEPTH)
	) u_rx_buf (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_in_valid(buf_push),
		.o_in_ready(buf_in_ready),
		.i_in_data(buf_data),
		.o_out_valid(o_rx_valid),
		.i_out_ready(i_rx_ready),
		.o_out_data(o_rx_data)
	);

	// A slave cannot stall the far master, so a full buffer drops the word
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			overrun_q <= OVERRUN_RST;
		end else if (buf_push && !buf_in_ready) begin
			overrun_q <= 1'b1;
		end else if (i_overrun_clear) begin
			overrun_q <= 1'b0;
		end
	end

	// Sticky; a new fault beats a clear in the same cycle
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			mode_fault_q <= MODE_FAULT_RST;
		end else if (master_fault || slave_fault) begin
			mode_fault_q <= 1'b1;
		end else if (i_mode_fault_clear) begin
			mode_fault_q <= 1'b0;
		end
	end

	// ==========================================================================
	// Shared receive/error interrupt
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			o_rx_error_irq <= 1'b0;
		end else begin
			o_rx_error_irq <= (error_irq_enable_q && (mode_fault_q || overrun_q))
				|| (rx_irq_enable_q && o_rx_valid);
		end
	end

	assign o_port_enable = port_enable_q;
	assign o_master_select = master_select_q;
	assign o_error_irq_enable = error_irq_enable_q;
	assign o_rx_irq_enable = rx_irq_enable_q;
	assign o_mode_fault_flag = mode_fault_q;
	assign o_overrun_flag = overrun_q;
	assign o_transmit_empty_flag = transmit_empty_q;
	assign o_receive_full_flag = o_rx_valid;
endmodule : spimf_top

// file: verilog/spimf_note_unused.sv
// Spare design file; holds no logic

// file: bench/spimf_assertions.sv
// Concurrent checks on the mode-fault port block
`timescale 1ns/1ns
module spimf_checker (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	// Watched inputs
	input wire logic i_ctrl_wr,
	input wire logic i_fault_detect_enable,
	input wire logic i_clock_phase,
	input wire logic i_mode_fault_clear,
	input wire logic i_select_n,
	// Watched outputs
	input wire logic o_port_enable,
	input wire logic o_master_select,
	input wire logic o_error_irq_enable,
	input wire logic o_rx_irq_enable,
	input wire logic o_mode_fault_flag,
	input wire logic o_overrun_flag,
	input wire logic o_transmit_empty_flag,
	input wire logic o_rx_valid,
	input wire logic o_pins_by_port,
	input wire logic o_rx_error_irq,
	input wire logic o_serial_clock_oe,
	input wire logic o_mosi_oe
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);
	// ==========================================================================
	// Interrupt and fault flag
	a_irq_on_fault: assert property (o_mode_fault_flag && o_error_irq_enable |=> o_rx_error_irq)
		else $error("fault with error enable gave no interrupt");
	a_irq_has_cause: assert property (o_rx_error_irq |-> $past((o_error_irq_enable && (o_mode_fault_flag
		|| o_overrun_flag)) || (o_rx_irq_enable && o_rx_valid)))
		else $error("interrupt without a cause");
	a_fault_needs_en: assert property ($rose(o_mode_fault_flag) |-> $past(i_fault_detect_enable))
		else $error("fault set with detection off");
	a_master_fault_time: assert property ((o_port_enable && o_master_select && i_fault_detect_enable
		&& !i_select_n)[*3] |=> o_mode_fault_flag)
		else $error("master fault late");
	a_fault_stops_port: assert property ($rose(o_mode_fault_flag) && $past(o_master_select && o_port_enable)
		|-> !o_port_enable && o_transmit_empty_flag && o_pins_by_port && !o_mosi_oe && !o_serial_clock_oe)
		else $error("master fault left port running");
	a_fault_keeps_role: assert property ($rose(o_mode_fault_flag) && !$past(i_ctrl_wr)
		|-> o_master_select == $past(o_master_select))
		else $error("fault changed master select");
	a_fault_sticky: assert property (o_mode_fault_flag && !i_mode_fault_clear |=> o_mode_fault_flag)
		else $error("fault flag dropped without clear");
	a_disabled_idle: assert property (!o_port_enable |-> o_pins_by_port && !o_serial_clock_oe && !o_mosi_oe)
		else $error("disabled port drives pins");
	// Short select pulse is far below one word, so no frame can close inside it
	a_slave_blip: assert property ((!o_master_select && o_port_enable && i_fault_detect_enable && !i_clock_phase
		&& $fell(i_select_n)) ##1 (!i_select_n)[*4] ##1 i_select_n[*4] |-> ##[0:6] o_mode_fault_flag)
		else $error("slave deselect gave no fault");
	// ==========================================================================
	// Coverage
	c_master_fault: cover property ($rose(o_mode_fault_flag) && o_master_select);
	c_slave_fault: cover property ($rose(o_mode_fault_flag) && !o_master_select);
	c_overrun: cover property ($rose(o_overrun_flag));
endmodule : spimf_checker

bind spimf_top spimf_checker spimf_checker_inst (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_ctrl_wr(i_ctrl_wr),
	.i_fault_detect_enable(i_fault_detect_enable), .i_clock_phase(i_clock_phase),
	.i_mode_fault_clear(i_mode_fault_clear), .i_select_n(i_select_n), .o_port_enable(o_port_enable),
	.o_master_select(o_master_select), .o_error_irq_enable(o_error_irq_enable), .o_rx_irq_enable(o_rx_irq_enable),
	.o_mode_fault_flag(o_mode_fault_flag), .o_overrun_flag(o_overrun_flag),
	.o_transmit_empty_flag(o_transmit_empty_flag), .o_rx_valid(o_rx_valid), .o_pins_by_port(o_pins_by_port),
	.o_rx_error_irq(o_rx_error_irq), .o_serial_clock_oe(o_serial_clock_oe), .o_mosi_oe(o_mosi_oe));

// file: bench/spimf_peer.sv
// Behavioural far-side master driving select, link clock and data
`timescale 1ns/1ns
module spimf_peer (
	// Link pins toward the block
	output logic o_serial_clock,
	output logic o_select_n,
	output logic o_mosi
);
	initial begin
		o_serial_clock = 1'h0;
		o_select_n = 1'h1;
		o_mosi = 1'h0;
	end
	// ==========================================================================
	// Select held by hand
	task hold_select(input logic lvl);
		o_select_n = lvl;
	endtask : hold_select
	// ==========================================================================
	// One frame at 125 ns, cut short after nbits; clock idles between frames
	task send(input logic [7:0] data, input logic clock_phase, input int nbits);
		int i;
		o_select_n = 1'h0;
		if (!clock_phase) o_mosi = data[7];
		#62;
		for (i = 0; i < nbits; i++) begin
			o_serial_clock = 1'h1;
			if (clock_phase) o_mosi = data[7 - i];
			#63;
			o_serial_clock = 1'h0;
			if (!clock_phase && i < 7) o_mosi = data[6 - i];
			#62;
		end
		o_select_n = 1'h1;
		// Released line must not keep the last bit
		o_mosi = ~o_mosi;
		// Gap so the block sees select high between frames
		#125;
	endtask : send
endmodule : spimf_peer

// file: bench/spimf_top_test.sv
// Self-checking bench for the mode-fault port block
`timescale 1ns/1ns
module spimf_top_test;
	logic clock = 1'h0, rst_n = 1'h1, ctrl_wr, wr_pe, wr_ms, wr_ee, wr_re, fde, clock_phase, mf_clr, ov_clr, rx_ready;
	logic port_en, mst, err_en, fault, overrun, tx_empty, pins_port, irq, rx_valid, mosi_o, mosi_oe;
	logic tx_valid, rx_en, rx_full, tx_ready, sclk_o, sclk_oe;
	logic [7:0] rx_data, tx_data;
	wire sclk, sel_n, mosi;
	int num_errors = 0;
	int tests_run = 0;
	always #4 clock = ~clock;
	spimf_top spimf_top_inst (.i_clock(clock), .i_rst_n(rst_n), .i_ctrl_wr(ctrl_wr), .i_wr_port_enable(wr_pe),
		.i_wr_master_select(wr_ms), .i_wr_error_irq_enable(wr_ee), .i_wr_rx_irq_enable(wr_re),
		.i_fault_detect_enable(fde), .i_clock_phase(clock_phase), .i_clock_polarity(1'h0), .i_mode_fault_clear(mf_clr),
		.i_overrun_clear(ov_clr), .o_port_enable(port_en), .o_master_select(mst), .o_error_irq_enable(err_en),
		.o_rx_irq_enable(rx_en), .o_mode_fault_flag(fault), .o_overrun_flag(overrun),
		.o_transmit_empty_flag(tx_empty), .o_receive_full_flag(rx_full), .o_pins_by_port(pins_port),
		.o_rx_error_irq(irq), .i_tx_valid(tx_valid), .o_tx_ready(tx_ready), .i_tx_data(tx_data),
		.o_rx_valid(rx_valid), .i_rx_ready(rx_ready), .o_rx_data(rx_data),
		.i_serial_clock(sclk), .i_select_n(sel_n), .i_mosi(mosi), .i_miso(mosi_o), .o_serial_clock(sclk_o),
		.o_serial_clock_oe(sclk_oe), .o_mosi(mosi_o), .o_mosi_oe(mosi_oe));
	spimf_peer spimf_peer_inst (.o_serial_clock(sclk), .o_select_n(sel_n), .o_mosi(mosi));
	// ==========================================================================
	// Shared helpers
	task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task test_done;
		$display("checks %0d errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : test_done
	task step(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : step
	task ctrl(input logic pe, input logic ms, input logic ee, input logic re);
		@(posedge clock);
		ctrl_wr <= 1'h1;
		wr_pe <= pe;
		wr_ms <= ms;
		wr_ee <= ee;
		wr_re <= re;
		step(1);
		ctrl_wr <= 1'h0;
	endtask : ctrl
	task pulse(input logic which_fault);
		@(posedge clock);
		if (which_fault) mf_clr <= 1'h1;
		else ov_clr <= 1'h1;
		@(posedge clock);
		mf_clr <= 1'h0;
		ov_clr <= 1'h0;
		#1;
	endtask : pulse
	// Bounded wait on the fault flag or on a received word
	task wait_on(input logic want_rx);
		int k;
		for (k = 0; k < 60; k++) begin
			if ((want_rx ? rx_valid : fault) === 1'h1) break;
			step(1);
		end
		if (k == 60) begin
			num_errors++;
			test_done;
		end
	endtask : wait_on
	task pop;
		@(posedge clock);
		rx_ready <= 1'h1;
		@(posedge clock);
		rx_ready <= 1'h0;
		#1;
	endtask : pop
	// ==========================================================================
	// Scenarios
	task t_reset;
		check("port_enable", port_en, 0);
		check("fault", fault, 0);
		check("error_enable", err_en, 0);
		check("tx_empty", tx_empty, 1);
		check("irq", irq, 0);
	endtask : t_reset
	task t_master_fault;
		ctrl(1, 1, 1, 0);
		check("pins_by_port", pins_port, 0);
		spimf_peer_inst.hold_select(0);
		wait_on(0);
		check("port_enable", port_en, 0);
		check("tx_empty", tx_empty, 1);
		check("master_select", mst, 1);
		check("pins_by_port", pins_port, 1);
		check("mosi_oe", mosi_oe, 0);
		step(1);
		check("irq", irq, 1);
		spimf_peer_inst.hold_select(1);
		step(6);
		check("fault held", fault, 1);
		pulse(1);
		check("fault cleared", fault, 0);
		// Port bits handed back before the port takes the pins again
		ctrl(1, 1, 1, 0);
		step(6);
		check("port_enable", port_en, 1);
		ctrl(0, 0, 0, 0);
	endtask : t_master_fault
	task t_no_detect;
		@(posedge clock);
		fde <= 1'h0;
		ctrl(1, 1, 0, 0);
		spimf_peer_inst.hold_select(0);
		step(10);
		check("fault off", fault, 0);
		check("port_enable", port_en, 1);
		ctrl(0, 1, 0, 0);
		fde <= 1'h1;
		step(10);
		check("fault idle", fault, 0);
		check("pins_by_port", pins_port, 1);
		spimf_peer_inst.hold_select(1);
		step(4);
	endtask : t_no_detect
	task t_slave_select;
		ctrl(1, 0, 1, 0);
		spimf_peer_inst.hold_select(0);
		step(5);
		spimf_peer_inst.hold_select(1);
		wait_on(0);
		check("master_select", mst, 0);
		pulse(1);
		ctrl(0, 0, 1, 0);
		clock_phase <= 1'h1;
		ctrl(1, 0, 1, 0);
		spimf_peer_inst.hold_select(0);
		step(5);
		spimf_peer_inst.hold_select(1);
		step(10);
		check("no frame no fault", fault, 0);
		spimf_peer_inst.send(8'h96, 1, 4);
		wait_on(0);
		check("cut word", rx_valid, 0);
		pulse(1);
		ctrl(0, 0, 1, 0);
		clock_phase <= 1'h0;
	endtask : t_slave_select
	task t_slave_words;
		ctrl(1, 0, 1, 1);
		check("rx_irq_enable", rx_en, 1);
		spimf_peer_inst.send(8'hA5, 0, 8);
		wait_on(1);
		step(6);
		check("fault full word", fault, 0);
		check("rx_data", rx_data, 8'hA5);
		check("irq", irq, 1);
		spimf_peer_inst.send(8'h3C, 0, 8);
		spimf_peer_inst.send(8'hE1, 0, 8);
		step(8);
		check("overrun", overrun, 1);
		check("fault", fault, 0);
		pop;
		check("rx_data", rx_data, 8'h3C);
		pop;
		check("rx_valid", rx_valid, 0);
		pulse(0);
		step(1);
		check("overrun", overrun, 0);
		check("irq", irq, 0);
	endtask : t_slave_words
	// Master word looped back from the data output to the data input
	task t_master_word;
		ctrl(1, 1, 0, 0);
		check("tx_ready", tx_ready, 1);
		@(posedge clock);
		tx_valid <= 1'h1;
		tx_data <= 8'h5A;
		@(posedge clock);
		tx_valid <= 1'h0;
		step(2);
		check("sclk_oe", sclk_oe, 1);
		step(120);
		wait_on(1);
		check("master word", rx_data, 8'h5A);
		check("rx_full", rx_full, 1);
		check("sclk idle", sclk_o, 0);
		check("fault", fault, 0);
		pop;
		ctrl(0, 0, 0, 0);
		check("sclk_oe off", sclk_oe, 0);
	endtask : t_master_word
	initial begin
		{ctrl_wr, wr_pe, wr_ms, wr_ee, wr_re, clock_phase, mf_clr, ov_clr, rx_ready, tx_valid} = 10'h000;
		tx_data = 8'h00;
		fde = 1'h1;
		// Late assert gives the link-side flops a clean falling reset edge
		#1;
		rst_n = 1'h0;
		repeat (10) @(posedge clock);
		rst_n <= 1'h1;
		step(1);
		t_reset;
		t_master_fault;
		t_no_detect;
		t_slave_select;
		t_slave_words;
		t_master_word;
		test_done;
	end
endmodule : spimf_top_test
